// ### hdl/csc_core.sv
// Purpose: cpu status word, core control word and stack underflow check
// Assumes: single clock, synchronous inputs, plain register port
// Notes: hardware flag updates beat software writes on the same bit
//
// Behaviour
// - stack pointer loads 0x0800 on reset; trap when it is below 0x0800
// - exception push word joins status low byte with pc upper byte
// - accumulator overflow flags and combined flag are read-only, dsp-owned
// - clip sticky flags set by dsp only; clearing combined clears both
// - combined overflow and combined sticky are ors of per-accumulator bits
// - loop_do_running shows a do loop is in progress, read-only
// - repeat_running shows a repeat loop is in progress, read-only
// - half carry from bit 4 for bytes, bit 8 for words
// - priority level is top bit joined above the three status bits
// - levels 0-7 or 8-15; value 111 blocks user interrupts
// - nesting_off makes the three priority bits read-only to software
// - negative flag follows sign of an affecting result
// - signed wrap flag set on two's complement overflow, else cleared
// - zero flag cleared on non-zero result; carry from result msb
// - mult_unsigned_sel picks unsigned or signed dsp multiplies
// - writing one to loop_early_exit ends the do loop; reads zero
// - loop_nest_depth reports active do loops, read-only
// - per-accumulator clip enables for accumulators a and b
// - store_clip_en enables clipped dsp stores, resets to one
// - clip_mode_wide picks 9.31 or 1.31 saturation
// - top priority bit set by hardware above 7; software reads or clears
// - prog_window_en maps program space into data space
// - round_biased_sel picks biased or convergent rounding
// - integer_mult_sel picks integer or fractional multiplies
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
`include "csc_map.svh"

module csc_core #(
  parameter int DW = 16,
  parameter int AW = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire csc_pkg::csc_alu_t alu_in,
  input wire csc_pkg::csc_dsp_t dsp_in,
  input wire logic [2:0] loop_nest_depth,
  input wire logic repeat_running,
  input wire logic nesting_off,
  input wire logic ipl_load,
  input wire logic [3:0] ipl_value,
  input wire logic sp_load,
  input wire logic [15:0] sp_value,
  input wire logic exc_push,
  input wire logic [7:0] pc_upper,
  output logic [15:0] push_word,
  output logic [15:0] push_addr,
  output logic push_valid,
  output logic [15:0] stack_ptr,
  output logic stack_err_trap,
  output logic loop_early_exit,
  output logic [3:0] cpu_priority,
  output logic user_int_blocked,
  output csc_pkg::csc_mode_t core_mode
);

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  logic wr_st, wr_cc, wr_sp;
  assign wr_st = reg_wr && (reg_addr == `CSC_IDX_STATUS);
  assign wr_cc = reg_wr && (reg_addr == `CSC_IDX_CORE);
  assign wr_sp = reg_wr && (reg_addr == `CSC_IDX_SP);

  logic acc_a_ovf, acc_b_ovf, acc_a_clip_sticky, acc_b_clip_sticky;
  logic either_acc_ovf, either_acc_clip_sticky, loop_do_running;
  logic half_carry_flag, negative_flag, signed_wrap_flag;
  logic zero_flag, carry_flag, cpu_priority_top_bit;
  logic [2:0] cpu_priority_low3;
  logic [15:0] status_word, core_control;

  // ------------------------------------------------------------------
  // dsp-owned flags
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_a_ovf <= 1'h0;
      acc_b_ovf <= 1'h0;
    end else if (dsp_in.upd) begin
      acc_a_ovf <= dsp_in.ovf_a;
      acc_b_ovf <= dsp_in.ovf_b;
    end
  end

  // set beats clear so a clip in the clearing cycle is not lost
  logic clr_sa, clr_sb, set_sa, set_sb;
  assign clr_sa = wr_st && (!reg_wdata[`CSC_ST_A_CLIP] ||
                            !reg_wdata[`CSC_ST_ANY_CLIP]);
  assign clr_sb = wr_st && (!reg_wdata[`CSC_ST_B_CLIP] ||
                            !reg_wdata[`CSC_ST_ANY_CLIP]);
  assign set_sa = dsp_in.upd && dsp_in.clip_a;
  assign set_sb = dsp_in.upd && dsp_in.clip_b;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_a_clip_sticky <= 1'h0;
      acc_b_clip_sticky <= 1'h0;
    end else begin
      if (set_sa) begin
        acc_a_clip_sticky <= 1'h1;
      end else if (clr_sa) begin
        acc_a_clip_sticky <= 1'h0;
      end
      if (set_sb) begin
        acc_b_clip_sticky <= 1'h1;
      end else if (clr_sb) begin
        acc_b_clip_sticky <= 1'h0;
      end
    end
  end

  assign either_acc_ovf = acc_a_ovf | acc_b_ovf;
  assign either_acc_clip_sticky = acc_a_clip_sticky | acc_b_clip_sticky;
  assign loop_do_running = (loop_nest_depth != 3'h0);

  // ------------------------------------------------------------------
  // alu flags
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      half_carry_flag <= 1'h0;
      negative_flag <= 1'h0;
      signed_wrap_flag <= 1'h0;
      zero_flag <= 1'h0;
      carry_flag <= 1'h0;
    end else if (alu_in.upd) begin
      half_carry_flag <= alu_in.byte_op ? alu_in.carry4 :
                         alu_in.carry8;
      negative_flag <= alu_in.neg;
      signed_wrap_flag <= alu_in.wrap;
      carry_flag <= alu_in.carry;
      // sticky mode only clears, for multi-word compare chains
      if (!alu_in.zero) begin
        zero_flag <= 1'h0;
      end else if (!alu_in.z_sticky) begin
        zero_flag <= 1'h1;
      end
    end else if (wr_st) begin
      half_carry_flag <= reg_wdata[`CSC_ST_HALF_CY];
      negative_flag <= reg_wdata[`CSC_ST_N];
      signed_wrap_flag <= reg_wdata[`CSC_ST_WRAP];
      zero_flag <= reg_wdata[`CSC_ST_Z];
      carry_flag <= reg_wdata[`CSC_ST_C];
    end
  end

  // ------------------------------------------------------------------
  // priority level
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_priority_low3 <= 3'h0;
    end else if (ipl_load) begin
      cpu_priority_low3 <= ipl_value[2:0];
    end else if (wr_st && !nesting_off) begin
      cpu_priority_low3 <=
        reg_wdata[`CSC_ST_PRIO_HI:`CSC_ST_PRIO_LO];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_priority_top_bit <= 1'h0;
    end else if (ipl_load) begin
      cpu_priority_top_bit <= ipl_value[3];
    end else if (wr_cc && !reg_wdata[`CSC_CC_PRIO_TOP]) begin
      cpu_priority_top_bit <= 1'h0;
    end
  end

  assign cpu_priority = {cpu_priority_top_bit, cpu_priority_low3};
  assign user_int_blocked = cpu_priority_top_bit ||
                            (cpu_priority_low3 == `CSC_PRIO_BLOCK);

  // ------------------------------------------------------------------
  // core control modes
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_mode <= '0;
      core_mode.store_clip_en <= `CSC_STORE_CLIP_RST;
    end else if (wr_cc) begin
      core_mode.mult_unsigned_sel <= reg_wdata[`CSC_CC_MUL_UNS];
      core_mode.acc_a_clip_en <= reg_wdata[`CSC_CC_A_CLIP_EN];
      core_mode.acc_b_clip_en <= reg_wdata[`CSC_CC_B_CLIP_EN];
      core_mode.store_clip_en <= reg_wdata[`CSC_CC_STORE_CLIP];
      core_mode.clip_mode_wide <= reg_wdata[`CSC_CC_CLIP_WIDE];
      core_mode.prog_window_en <= reg_wdata[`CSC_CC_PROG_WIN];
      core_mode.round_biased_sel <= reg_wdata[`CSC_CC_ROUND];
      core_mode.integer_mult_sel <= reg_wdata[`CSC_CC_INT_MUL];
    end
  end

  // one-cycle request to the loop hardware; the bit itself is not stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      loop_early_exit <= 1'h0;
    end else begin
      loop_early_exit <= wr_cc && reg_wdata[`CSC_CC_EARLY_EXIT];
    end
  end

  // ------------------------------------------------------------------
  // stack pointer and exception push
  // ------------------------------------------------------------------
  // bit 0 forced low so the stack stays word aligned
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stack_ptr <= `CSC_SP_RESET;
    end else if (exc_push) begin
      stack_ptr <= stack_ptr + `CSC_SP_STEP;
    end else if (sp_load) begin
      stack_ptr <= {sp_value[15:1], 1'h0};
    end else if (wr_sp) begin
      stack_ptr <= {reg_wdata[15:1], 1'h0};
    end
  end

  assign stack_err_trap = (stack_ptr < `CSC_SP_RESET);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      push_word <= 16'h0000;
      push_addr <= 16'h0000;
      push_valid <= 1'h0;
    end else begin
      push_valid <= exc_push;
      if (exc_push) begin
        push_word <= {pc_upper, status_word[7:0]};
        push_addr <= stack_ptr;
      end
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  assign status_word = {acc_a_ovf, acc_b_ovf, acc_a_clip_sticky,
                        acc_b_clip_sticky, either_acc_ovf,
                        either_acc_clip_sticky, loop_do_running,
                        half_carry_flag, cpu_priority_low3,
                        repeat_running, negative_flag, signed_wrap_flag,
                        zero_flag, carry_flag};
  // loop_early_exit position reads zero
  assign core_control = {3'h0, core_mode.mult_unsigned_sel, 1'h0,
                         loop_nest_depth, core_mode.acc_a_clip_en,
                         core_mode.acc_b_clip_en, core_mode.store_clip_en,
                         core_mode.clip_mode_wide, cpu_priority_top_bit,
                         core_mode.prog_window_en,
                         core_mode.round_biased_sel,
                         core_mode.integer_mult_sel};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CSC_IDX_STATUS: reg_rdata <= status_word;
        `CSC_IDX_CORE: reg_rdata <= core_control;
        `CSC_IDX_SP: reg_rdata <= stack_ptr;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_clip_a;
    dsp_in.upd && dsp_in.clip_a;
  endsequence
  sequence s_sab_clear;
    wr_st && !reg_wdata[`CSC_ST_ANY_CLIP] && !set_sa && !set_sb;
  endsequence

  a_sp_reset_val: assert property (
    $fell(rst) |-> stack_ptr == `CSC_SP_RESET)
    else $error("stack pointer not at reset value");
  a_sp_underflow: assert property (
    stack_err_trap == (stack_ptr[15:11] == 5'h00))
    else $error("stack trap does not match pointer");
  a_push_word: assert property (
    exc_push |=> push_valid &&
      push_word == {$past(pc_upper), $past(status_word[7:0])})
    else $error("exception push word wrong");
  a_push_step: assert property (
    exc_push |=> stack_ptr == $past(stack_ptr) + `CSC_SP_STEP)
    else $error("stack pointer did not step on push");
  a_ovf_dsp_only: assert property (
    !dsp_in.upd && !rst |=> $stable(acc_a_ovf) && $stable(acc_b_ovf))
    else $error("overflow flag moved without dsp");
  a_sticky_hold: assert property (
    s_clip_a |=> acc_a_clip_sticky ##1 (acc_a_clip_sticky || $past(clr_sa)))
    else $error("clip sticky lost");
  a_sab_clears: assert property (
    s_sab_clear |=> !acc_a_clip_sticky && !acc_b_clip_sticky)
    else $error("combined clear missed");
  a_combined_or: assert property (
    reg_rd && reg_addr == `CSC_IDX_STATUS |=>
      reg_rdata[`CSC_ST_ANY_OVF] == (reg_rdata[`CSC_ST_ACC_A_OVF] |
                                     reg_rdata[`CSC_ST_ACC_B_OVF]) &&
      reg_rdata[`CSC_ST_ANY_CLIP] == (reg_rdata[`CSC_ST_A_CLIP] |
                                      reg_rdata[`CSC_ST_B_CLIP]))
    else $error("combined flag wrong");
  a_do_running: assert property (
    reg_rd && reg_addr == `CSC_IDX_STATUS |=>
      reg_rdata[`CSC_ST_DO_RUN] == ($past(loop_nest_depth) != 3'h0))
    else $error("do loop flag does not follow depth");
  a_ipl_locked: assert property (
    !rst && nesting_off && !ipl_load |=> $stable(cpu_priority_low3))
    else $error("priority bits changed while locked");
  a_block_user: assert property (
    cpu_priority_low3 == `CSC_PRIO_BLOCK |-> user_int_blocked)
    else $error("level 111 did not block");
  a_top_bit_hw: assert property (
    !ipl_load && !cpu_priority_top_bit |=> !cpu_priority_top_bit)
    else $error("top priority bit set without hardware");
  a_top_bit_clr: assert property (
    wr_cc && !ipl_load && !reg_wdata[`CSC_CC_PRIO_TOP] |=>
      !cpu_priority_top_bit)
    else $error("top priority bit not cleared");
  a_hw_wins: assert property (
    alu_in.upd && wr_st |=> carry_flag == $past(alu_in.carry))
    else $error("software beat hardware on carry");
  a_early_exit: assert property (
    wr_cc && reg_wdata[`CSC_CC_EARLY_EXIT] |=> loop_early_exit ##1
      (!loop_early_exit || $past(wr_cc)))
    else $error("early exit pulse wrong");
  a_exit_reads_zero: assert property (
    reg_rd && reg_addr == `CSC_IDX_CORE |=>
      !reg_rdata[`CSC_CC_EARLY_EXIT])
    else $error("early exit bit read as one");
  a_store_clip_en_reset: assert property (
    $fell(rst) |-> core_mode.store_clip_en)
    else $error("store clip enable not set at reset");

endmodule

// ### hdl/csc_map.svh
// Purpose: offsets, field positions, reset values of the status/control bank
// Assumes: word-indexed register port, 16-bit data
// Notes: byte address of a register is twice its index
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH
// --------------------------------------------------------------------
// register indices
// --------------------------------------------------------------------
`define CSC_IDX_STATUS 4'h0
`define CSC_IDX_CORE 4'h1
`define CSC_IDX_SP 4'h2
// --------------------------------------------------------------------
// status word fields
// --------------------------------------------------------------------
`define CSC_ST_ACC_A_OVF 15
`define CSC_ST_ACC_B_OVF 14
`define CSC_ST_A_CLIP 13
`define CSC_ST_B_CLIP 12
`define CSC_ST_ANY_OVF 11
`define CSC_ST_ANY_CLIP 10
`define CSC_ST_DO_RUN 9
`define CSC_ST_HALF_CY 8
`define CSC_ST_PRIO_HI 7
`define CSC_ST_PRIO_LO 5
`define CSC_ST_RPT_RUN 4
`define CSC_ST_N 3
`define CSC_ST_WRAP 2
`define CSC_ST_Z 1
`define CSC_ST_C 0
// --------------------------------------------------------------------
// core control fields and reset values
// --------------------------------------------------------------------
`define CSC_CC_MUL_UNS 12
`define CSC_CC_EARLY_EXIT 11
`define CSC_CC_DEPTH_HI 10
`define CSC_CC_DEPTH_LO 8
`define CSC_CC_A_CLIP_EN 7
`define CSC_CC_B_CLIP_EN 6
`define CSC_CC_STORE_CLIP 5
`define CSC_CC_CLIP_WIDE 4
`define CSC_CC_PRIO_TOP 3
`define CSC_CC_PROG_WIN 2
`define CSC_CC_ROUND 1
`define CSC_CC_INT_MUL 0
`define CSC_STORE_CLIP_RST 1'h1
`define CSC_SP_RESET 16'h0800
`define CSC_SP_STEP 16'h0002
`define CSC_PRIO_BLOCK 3'h7
`endif

// ### hdl/csc_pkg.sv
// Purpose: carrier types of the status/control bank
// Assumes: alu and dsp types driven by those units, mode type by the core
// Notes: constants live in csc_map.svh
package csc_pkg;
  // alu flag update, one-cycle valid
  typedef struct packed {
    logic upd;
    logic byte_op;
    logic neg;
    logic wrap;
    logic zero;
    logic z_sticky;
    logic carry;
    logic carry4;
    logic carry8;
  } csc_alu_t;
  // dsp engine flag update, one-cycle valid
  typedef struct packed {
    logic upd;
    logic ovf_a;
    logic ovf_b;
    logic clip_a;
    logic clip_b;
  } csc_dsp_t;
  // decoded core control modes
  typedef struct packed {
    logic mult_unsigned_sel;
    logic acc_a_clip_en;
    logic acc_b_clip_en;
    logic store_clip_en;
    logic clip_mode_wide;
    logic prog_window_en;
    logic round_biased_sel;
    logic integer_mult_sel;
  } csc_mode_t;
endpackage

// ### test/csc_far_model.sv
// Purpose: far-side model of the alu, dsp engine and loop hardware
// Assumes: bench commands arrive one cycle before the flags leave
// Notes: alu flags come from a real add, so table rows cannot agree by luck
`timescale 1ns/10ps
module csc_far_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic op_go,
  input wire logic op_byte,
  input wire logic op_zs,
  input wire logic [15:0] op_a,
  input wire logic [15:0] op_b,
  input wire logic dsp_go,
  input wire logic [3:0] dsp_flags,
  input wire logic do_enter,
  input wire logic rpt_on,
  input wire logic early_exit,
  output csc_pkg::csc_alu_t alu_out,
  output csc_pkg::csc_dsp_t dsp_out,
  output logic [2:0] depth_out,
  output logic rpt_out
);
  // ----------------------------------------------------------------
  // adder and flag outputs
  // ----------------------------------------------------------------
  logic [16:0] s16;
  logic [8:0] s8;
  logic [4:0] s4;
  logic neg;
  logic wrap;
  logic zero;
  logic cy;
  assign s16 = {1'h0, op_a} + {1'h0, op_b};
  assign s8 = {1'h0, op_a[7:0]} + {1'h0, op_b[7:0]};
  assign s4 = {1'h0, op_a[3:0]} + {1'h0, op_b[3:0]};
  assign neg = op_byte ? s8[7] : s16[15];
  assign zero = op_byte ? (s8[7:0] == 8'h00) : (s16[15:0] == 16'h0000);
  assign cy = op_byte ? s8[8] : s16[16];
  assign wrap = op_byte ? (op_a[7] == op_b[7]) && (s8[7] != op_a[7])
                        : (op_a[15] == op_b[15]) && (s16[15] != op_a[15]);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alu_out <= '0;
      dsp_out <= '0;
      rpt_out <= 1'h0;
    end else begin
      alu_out <= {op_go, op_byte, neg, wrap, zero, op_zs, cy, s4[4], s8[8]};
      dsp_out <= {dsp_go, dsp_flags};
      rpt_out <= rpt_on;
    end
  end
  // an early exit drops one nesting level, as the real loop unit would
  always_ff @(posedge ref_clk) begin
    if (rst)
      depth_out <= 3'h0;
    else if (do_enter)
      depth_out <= depth_out + 3'h1;
    else if (early_exit)
      depth_out <= depth_out - 3'h1;
  end
endmodule

// ### test/test_cpu_status_core_control.sv
// Purpose: self-checking bench of the status and core control bank
// Assumes: register index 0 status, 1 core control, 2 stack pointer
// Notes: the seven plain alu add cases run from a table, the rest are hand-written
`timescale 1ns/10ps
module test_cpu_status_core_control;
  // ----------------------------------------------------------------
  // stimulus, model and design
  // ----------------------------------------------------------------
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [15:0] reg_rdata;
  logic nesting_off = 1'h0;
  logic ipl_load = 1'h0;
  logic [3:0] ipl_value = 4'h0;
  logic sp_load = 1'h0;
  logic [15:0] sp_value = 16'h0000;
  logic exc_push = 1'h0;
  logic [7:0] pc_upper = 8'h00;
  logic op_go = 1'h0;
  logic op_byte = 1'h0;
  logic op_zs = 1'h0;
  logic [15:0] stack_ptr;
  logic [15:0] op_a = 16'h0000;
  logic [15:0] op_b = 16'h0000;
  logic dsp_go = 1'h0;
  logic [3:0] dsp_flags = 4'h0;
  logic do_enter = 1'h0;
  logic rpt_on = 1'h0;
  csc_pkg::csc_alu_t alu_in;
  csc_pkg::csc_dsp_t dsp_in;
  csc_pkg::csc_mode_t core_mode;
  logic [2:0] depth;
  logic rpt;
  logic [15:0] push_word;
  logic [15:0] push_addr;
  logic push_valid;
  logic stack_err_trap;
  logic loop_early_exit;
  logic [3:0] cpu_priority;
  logic user_int_blocked;
  int mismatches = 0;
  int cmp_count = 0;
  // byte_op, a, b, expected dc/n/ov/z/c
  logic [48:0] rows [7] = '{
    {1'h0, 16'h0001, 16'h0001, 16'h0000},
    {1'h0, 16'hffff, 16'h0001, 16'h0103},
    {1'h0, 16'h7fff, 16'h0001, 16'h010c},
    {1'h0, 16'h0080, 16'h0080, 16'h0100},
    {1'h1, 16'h000f, 16'h0001, 16'h0100},
    {1'h1, 16'h007f, 16'h0001, 16'h010c},
    {1'h1, 16'h00ff, 16'h0001, 16'h0103}};

  always #5 ref_clk = ~ref_clk;

  csc_far_model fm (.ref_clk(ref_clk), .rst(rst), .op_go(op_go),
    .op_byte(op_byte), .op_zs(op_zs), .op_a(op_a), .op_b(op_b),
    .dsp_go(dsp_go), .dsp_flags(dsp_flags), .do_enter(do_enter),
    .rpt_on(rpt_on),
    .early_exit(loop_early_exit), .alu_out(alu_in), .dsp_out(dsp_in),
    .depth_out(depth), .rpt_out(rpt));

  csc_core uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .alu_in(alu_in), .dsp_in(dsp_in),
    .loop_nest_depth(depth), .repeat_running(rpt),
    .nesting_off(nesting_off), .ipl_load(ipl_load), .ipl_value(ipl_value),
    .sp_load(sp_load), .sp_value(sp_value), .exc_push(exc_push),
    .pc_upper(pc_upper), .push_word(push_word), .push_addr(push_addr),
    .push_valid(push_valid), .stack_ptr(stack_ptr),
    .stack_err_trap(stack_err_trap),
    .loop_early_exit(loop_early_exit), .cpu_priority(cpu_priority),
    .user_int_blocked(user_int_blocked), .core_mode(core_mode));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [15:0] m,
                       input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    rdchk(4'h2, 16'hffff, 16'h0800);
    rdchk(4'h1, 16'hffff, 16'h0020);
    rdchk(4'h0, 16'hffff, 16'h0000);
    rdchk(4'h3, 16'hffff, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      op_byte <= rows[i][48];
      op_a <= rows[i][47:32];
      op_b <= rows[i][31:16];
      op_go <= 1'h1;
      @(posedge ref_clk);
      op_go <= 1'h0;
      rdchk(4'h0, 16'h010f, rows[i][15:0]);
    end
    // dsp sets overflow a and clip b; software cannot set them, and clearing combined clears clip b
    @(posedge ref_clk);
    dsp_go <= 1'h1;
    dsp_flags <= 4'b1001;
    @(posedge ref_clk);
    dsp_go <= 1'h0;
    rdchk(4'h0, 16'hfc00, 16'h9c00);
    wr(4'h0, 16'hfc00);
    rdchk(4'h0, 16'hfc00, 16'h9c00);
    wr(4'h0, 16'hf800);
    rdchk(4'h0, 16'hfc00, 16'h8800);
    // a sticky-zero byte op with a zero result leaves a clear zero flag
    @(posedge ref_clk);
    op_a <= 16'hffff;
    op_b <= 16'h0001;
    op_zs <= 1'h1;
    op_go <= 1'h1;
    @(posedge ref_clk);
    op_go <= 1'h0;
    op_zs <= 1'h0;
    rdchk(4'h0, 16'h0003, 16'h0001);
    // two nested do loops and a repeat loop
    repeat (2) begin
      @(posedge ref_clk);
      do_enter <= 1'h1;
      rpt_on <= 1'h1;
      @(posedge ref_clk);
      do_enter <= 1'h0;
    end
    rdchk(4'h1, 16'h0700, 16'h0200);
    rdchk(4'h0, 16'h0210, 16'h0210);
    rpt_on <= 1'h0;
    wr(4'h1, 16'hffff);
    #1 chk({15'h0, loop_early_exit}, 16'h0001);
    chk({8'h0, core_mode}, 16'h00ff);
    rdchk(4'h1, 16'hffff, 16'h11f7);
    wr(4'h1, 16'h0000);
    #1 chk({8'h0, core_mode}, 16'h0000);
    // hardware raises the level above 7
    @(posedge ref_clk);
    ipl_load <= 1'h1;
    ipl_value <= 4'hb;
    @(posedge ref_clk);
    ipl_load <= 1'h0;
    #1 chk({12'h0, cpu_priority}, 16'h000b);
    chk({15'h0, user_int_blocked}, 16'h0001);
    rdchk(4'h0, 16'h00e0, 16'h0060);
    rdchk(4'h1, 16'h0008, 16'h0008);
    wr(4'h1, 16'h0000);
    rdchk(4'h1, 16'h0008, 16'h0000);
    wr(4'h0, 16'h00e0);
    #1 chk({15'h0, user_int_blocked}, 16'h0001);
    wr(4'h0, 16'h0040);
    #1 chk({11'h0, user_int_blocked, cpu_priority}, 16'h0002);
    nesting_off <= 1'h1;
    wr(4'h0, 16'h00e0);
    rdchk(4'h0, 16'h00e0, 16'h0040);
    nesting_off <= 1'h0;
    // exception push of pc upper byte and status low byte
    @(posedge ref_clk);
    exc_push <= 1'h1;
    pc_upper <= 8'h5a;
    @(posedge ref_clk);
    exc_push <= 1'h0;
    #1 chk({15'h0, push_valid}, 16'h0001);
    chk(push_word, 16'h5a40);
    chk(push_addr, 16'h0800);
    chk(stack_ptr, 16'h0802);
    // hardware carry and a software clear meet in one cycle
    @(posedge ref_clk);
    op_byte <= 1'h0;
    op_a <= 16'hffff;
    op_b <= 16'h0001;
    op_go <= 1'h1;
    @(posedge ref_clk);
    op_go <= 1'h0;
    reg_addr <= 4'h0;
    reg_wdata <= 16'h0000;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    rdchk(4'h0, 16'h0103, 16'h0103);
    // stack pointer below the reserved area, then a second reset
    @(posedge ref_clk);
    sp_load <= 1'h1;
    sp_value <= 16'h07fe;
    @(posedge ref_clk);
    sp_load <= 1'h0;
    #1 chk({15'h0, stack_err_trap}, 16'h0001);
    @(posedge ref_clk);
    rst <= 1'h1;
    @(posedge ref_clk);
    rst <= 1'h0;
    rdchk(4'h2, 16'hffff, 16'h0800);
    chk({15'h0, stack_err_trap}, 16'h0000);
    end_sim();
  end
endmodule
